// ---- shared/sad_pkg.sv ----
// constants, tables and types of the sine address divider
// assumes one 125 MHz clock and a plain strobe register port
//
// What this block does
// - drive pulse gated with clock is the only stepping source
// - division ratio follows the range selected in the synthesizer
// - outputs are polarity switching signals and 9-bit sine table addresses
// - sine table holds one quadrant, 390 positive magnitudes
// - sine table address comes straight from an up/down counter
// - quadrant count inverts alternate half-cycles and sets count direction
// - each gated pulse off the boundary adds or subtracts a step from the addend table
// - two active-low range lines pick the step value
// - step is 1 on ranges 0-5, 5 on range 6, 10 above
// - full cycle is 1560, 312 or 156 gated pulses
// - quadrant counter advances when address equals the boundary value
// - addend table holds steps and reload values as listed
// - end-of-count table holds the listed boundary and reset values
// - every don't-care table location is zero
// - output sine is scaled by the software amplitude register
// - bias magnitude and sign follow the software bias register
package sad_pkg;

  // -----------------------------------------------------------------
  // geometry
  // -----------------------------------------------------------------
  localparam int          ADDR_W    = 9;
  localparam int          MAG_W     = 12;
  localparam int          QUAD_LEN  = 390;
  localparam int          FIFO_DEPTH = 16;
  localparam longint      SINE_SPAN = 1560;
  localparam longint      SINE_FULL = 4095;

  // -----------------------------------------------------------------
  // register map, byte addresses
  // -----------------------------------------------------------------
  localparam logic [7:0]  REG_AMPL    = 8'h00;
  localparam logic [7:0]  REG_BIAS    = 8'h04;
  localparam logic [7:0]  REG_CTRL    = 8'h08;
  localparam logic [7:0]  REG_STATUS  = 8'h0c;
  localparam logic [7:0]  REG_TBLIDX  = 8'h10;
  localparam logic [7:0]  REG_ADDEND  = 8'h14;
  localparam logic [7:0]  REG_EOC     = 8'h18;
  localparam logic [7:0]  AMPL_RESET  = 8'h00;
  localparam logic [7:0]  BIAS_RESET  = 8'h00;
  localparam int          BIAS_SIGN   = 7;
  localparam int          CTRL_RUN    = 0;
  localparam int          ST_QUAD     = 16;
  localparam int          ST_DOWN     = 18;
  localparam int          ST_RANGE    = 20;
  localparam logic [4:0]  STEP_BASE   = 5'h1c;

  // -----------------------------------------------------------------
  // tables, unlisted nibbles programmed as zero
  // -----------------------------------------------------------------
  localparam logic [0:31][7:0] ADDEND_ROM = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hf0, 8'hf0, 8'hf0, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h0d, 8'h09, 8'h0b, 8'h00, 8'h0d, 8'h09, 8'h0b,
    8'h00, 8'ha0, 8'h50, 8'he0, 8'h00, 8'h50, 8'ha0, 8'h10};
  localparam logic [0:31][7:0] EOC_ROM = {
    8'h00, 8'h0d, 8'h19, 8'h03, 8'h00, 8'h7a, 8'h6d, 8'h84,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef struct packed {
    logic             negative;
    logic [MAG_W-1:0] magnitude;
  } sad_sample_t;

endpackage

// ---- core/sad_divider.sv ----
// sine address divider with its sample fifo
// assumes drive pulse and range lines are asynchronous pins
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps

// -------------------------------------------------------------------
// sample fifo with registered output stage
// -------------------------------------------------------------------
module sad_fifo #(
  parameter int W     = 13,
  parameter int DEPTH = 16
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [CW-1:0] count_q, count_d;
  logic          valid_q, valid_d;
  logic [W-1:0]  data_q, data_d;
  logic          push, pop;

  always_comb begin
    inReady = (count_q != CW'(DEPTH));
    push    = inValid && inReady;
    pop     = (count_q != '0) && (!valid_q || outReady);
    wrPtr_d = push ? wrPtr_q + PW'(1) : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + PW'(1) : rdPtr_q;
    count_d = count_q + CW'(push) - CW'(pop);
    valid_d = pop ? 1'b1 : (outReady ? 1'b0 : valid_q);
    data_d  = pop ? mem[rdPtr_q] : data_q;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      valid_q <= 1'b0;
      data_q  <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
      valid_q <= valid_d;
      data_q  <= data_d;
    end
  end

  // storage needs no reset, only words below count are read
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  assign outValid = valid_q;
  assign outData  = data_q;
endmodule

// -------------------------------------------------------------------
// divider top
// -------------------------------------------------------------------
module sad_divider (
  input  wire logic                      clock,
  input  wire logic                      resetn,
  input  wire logic                      synthDrivePulse,
  input  wire logic                      rangeSelectAN,
  input  wire logic                      rangeSelectBN,
  input  wire logic [7:0]                regAddr,
  input  wire logic [31:0]               regWrData,
  input  wire logic                      regWrite,
  input  wire logic                      regRead,
  output logic [31:0]                    regRdData,
  output logic [sad_pkg::ADDR_W-1:0]     romAddr,
  output logic                           polarityNeg,
  output logic                           polarityPos,
  output logic                           sampleValid,
  input  wire logic                      sampleReady,
  output sad_pkg::sad_sample_t           sampleData,
  output logic                           biasNegative,
  output logic [6:0]                     biasMagnitude
);
  localparam int AW = sad_pkg::ADDR_W;
  localparam int MW = sad_pkg::MAG_W;
  localparam int SW = $bits(sad_pkg::sad_sample_t);

  // -----------------------------------------------------------------
  // one-quadrant sine table, filled at elaboration
  // -----------------------------------------------------------------
  function automatic logic [MW-1:0] sineAt(input int unsigned idx);
    longint unsigned p, q, num, den;
    p   = 2 * longint'(idx) + 1;
    q   = p * (sad_pkg::SINE_SPAN - p);
    num = 16 * q * sad_pkg::SINE_FULL;
    den = 5 * sad_pkg::SINE_SPAN * sad_pkg::SINE_SPAN - 4 * q;
    return MW'(num / den);
  endfunction

  logic [MW-1:0] sineRom [sad_pkg::QUAD_LEN];
  for (genvar g = 0; g < sad_pkg::QUAD_LEN; g++) begin : g_sine
    assign sineRom[g] = sineAt(g);
  end

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic drv1_q, drv2_q, drv3_q;
  logic rngA1_q, rngA2_q, rngB1_q, rngB2_q;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      drv1_q  <= 1'b0;
      drv2_q  <= 1'b0;
      drv3_q  <= 1'b0;
      rngA1_q <= 1'b1;
      rngA2_q <= 1'b1;
      rngB1_q <= 1'b1;
      rngB2_q <= 1'b1;
    end else begin
      drv1_q  <= synthDrivePulse;
      drv2_q  <= drv1_q;
      drv3_q  <= drv2_q;
      rngA1_q <= rangeSelectAN;
      rngA2_q <= rngA1_q;
      rngB1_q <= rangeSelectBN;
      rngB2_q <= rngB1_q;
    end
  end

  // -----------------------------------------------------------------
  // register file
  // -----------------------------------------------------------------
  logic [7:0]  ampl_q, ampl_d, bias_q, bias_d;
  logic        run_q, run_d;
  logic [4:0]  tblIdx_q, tblIdx_d;
  logic [31:0] rd_q, rd_d;
  logic [AW-1:0] addr_q;
  logic [1:0]  quad_q;
  logic        down_q;

  always_comb begin
    ampl_d   = ampl_q;
    bias_d   = bias_q;
    run_d    = run_q;
    tblIdx_d = tblIdx_q;
    rd_d     = '0;
    if (regWrite) begin
      case (regAddr)
        sad_pkg::REG_AMPL:   ampl_d = regWrData[7:0];
        sad_pkg::REG_BIAS:   bias_d = regWrData[7:0];
        sad_pkg::REG_CTRL:   run_d = regWrData[sad_pkg::CTRL_RUN];
        sad_pkg::REG_TBLIDX: tblIdx_d = regWrData[4:0];
        default:             ;
      endcase
    end
    if (regRead) begin
      case (regAddr)
        sad_pkg::REG_AMPL:   rd_d[7:0] = ampl_q;
        sad_pkg::REG_BIAS:   rd_d[7:0] = bias_q;
        sad_pkg::REG_CTRL:   rd_d[sad_pkg::CTRL_RUN] = run_q;
        sad_pkg::REG_STATUS: begin
          rd_d[AW-1:0] = addr_q;
          rd_d[sad_pkg::ST_QUAD +: 2] = quad_q;
          rd_d[sad_pkg::ST_DOWN] = down_q;
          rd_d[sad_pkg::ST_RANGE +: 2] = {rngA2_q, rngB2_q};
        end
        sad_pkg::REG_TBLIDX: rd_d[4:0] = tblIdx_q;
        sad_pkg::REG_ADDEND: rd_d[7:0] = sad_pkg::ADDEND_ROM[tblIdx_q];
        sad_pkg::REG_EOC:    rd_d[7:0] = sad_pkg::EOC_ROM[tblIdx_q];
        default:             rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ampl_q   <= sad_pkg::AMPL_RESET;
      bias_q   <= sad_pkg::BIAS_RESET;
      run_q    <= 1'b0;
      tblIdx_q <= '0;
      rd_q     <= '0;
    end else begin
      ampl_q   <= ampl_d;
      bias_q   <= bias_d;
      run_q    <= run_d;
      tblIdx_q <= tblIdx_d;
      rd_q     <= rd_d;
    end
  end

  // -----------------------------------------------------------------
  // address counter and quadrant counter
  // -----------------------------------------------------------------
  logic          pend_q, pend_d;
  logic [AW-1:0] addr_d;
  logic [1:0]    quad_d;
  logic          down_d;
  logic [AW-1:0] step, top, bound;
  logic          stepNow, fifoReady;
  logic [MW+7:0] scaled;
  logic          polPos_q;
  sad_pkg::sad_sample_t pushData;

  always_comb begin
    // the addend table answers the two-flop synchronised range lines directly
    step    = AW'(sad_pkg::ADDEND_ROM[{sad_pkg::STEP_BASE[4:2], rngA2_q, rngB2_q}][7:4]);
    top     = AW'(sad_pkg::QUAD_LEN) - step;
    bound   = down_q ? '0 : top;
    // one pulse waits while the fifo is full, further pulses merge into it
    stepNow = pend_q && run_q && fifoReady;
    pend_d  = (drv2_q && !drv3_q) || (pend_q && !stepNow);
    addr_d  = addr_q;
    quad_d  = quad_q;
    down_d  = down_q;
    if (stepNow) begin
      if (addr_q == bound) begin
        quad_d = quad_q + 2'd1;
        down_d = !down_q;
        addr_d = bound;
      end else if (down_q) begin
        addr_d = (addr_q > step) ? addr_q - step : '0;
      end else begin
        addr_d = (addr_q + step > top) ? top : addr_q + step;
      end
    end
    scaled             = sineRom[addr_d] * ampl_q;
    pushData.negative  = quad_d[1];
    pushData.magnitude = scaled[MW+7:8];
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pend_q <= 1'b0;
      addr_q <= '0;
      quad_q <= '0;
      down_q <= 1'b0;
      // own flop so the positive line is not a gate behind the counter
      polPos_q <= 1'b1;
    end else begin
      polPos_q <= !quad_d[1];
      pend_q <= pend_d;
      addr_q <= addr_d;
      quad_q <= quad_d;
      down_q <= down_d;
    end
  end

  // -----------------------------------------------------------------
  // sample path
  // -----------------------------------------------------------------
  logic [SW-1:0] fifoOut;

  sad_fifo #(
    .W     (SW),
    .DEPTH (sad_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock    (clock),
    .resetn   (resetn),
    .inValid  (stepNow),
    .inReady  (fifoReady),
    .inData   (pushData),
    .outValid (sampleValid),
    .outReady (sampleReady),
    .outData  (fifoOut)
  );

  assign sampleData    = sad_pkg::sad_sample_t'(fifoOut);
  assign regRdData     = rd_q;
  assign romAddr       = addr_q;
  assign polarityNeg   = quad_q[1];
  assign polarityPos   = polPos_q;
  assign biasNegative  = bias_q[sad_pkg::BIAS_SIGN];
  assign biasMagnitude = bias_q[6:0];
endmodule

// ---- sim/sad_divider_monitor.sv ----
// port checker of the sine address divider
// assumes one clock domain, bound onto sad_divider
`timescale 1ns/10ps
module sad_divider_monitor (
  input wire logic                       clock,
  input wire logic                       resetn,
  input wire logic                       regRead,
  input wire logic [31:0]                regRdData,
  input wire logic [sad_pkg::ADDR_W-1:0] romAddr,
  input wire logic                       polarityNeg,
  input wire logic                       polarityPos,
  input wire logic                       sampleValid,
  input wire logic                       sampleReady,
  input wire sad_pkg::sad_sample_t       sampleData
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  property p_polPair; polarityPos == !polarityNeg; endproperty
  property p_rdIdle; !regRead |=> regRdData == 32'h0; endproperty
  // reset itself is the antecedent, so no disable here
  property p_rst; disable iff (1'b0) !resetn |=> romAddr == 9'h000 && !polarityNeg; endproperty
  property p_step;
    $past(resetn) && $changed(romAddr) |-> (romAddr - $past(romAddr)) inside {9'h001, 9'h005, 9'h00a}
      || ($past(romAddr) - romAddr) inside {9'h001, 9'h005, 9'h00a};
  endproperty
  property p_max; romAddr <= 9'h185; endproperty
  property p_polEdge; $changed(polarityNeg) |-> romAddr == 9'h000; endproperty
  property p_push; $past(resetn) && $changed(romAddr) |-> ##[0:4] sampleValid; endproperty
  property p_hold; sampleValid && !sampleReady |=> sampleValid && $stable(sampleData); endproperty
  a_polPair: assert property (p_polPair) else $error("polarity pair not complementary");
  a_rdIdle: assert property (p_rdIdle) else $error("read data without read");
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_step: assert property (p_step) else $error("address moved by a bad step");
  a_max: assert property (p_max) else $error("address beyond quadrant");
  a_polEdge: assert property (p_polEdge) else $error("polarity flipped off zero");
  a_push: assert property (p_push) else $error("step without sample");
  a_hold: assert property (p_hold) else $error("sample changed while stalled");
  c_neg: cover property ($rose(polarityNeg));
  c_stall: cover property ((sampleValid && !sampleReady) [*8]);
  c_read: cover property (regRead);
endmodule
bind sad_divider sad_divider_monitor i_sad_divider_monitor (.clock, .resetn, .regRead, .regRdData, .romAddr,
  .polarityNeg, .polarityPos, .sampleValid, .sampleReady, .sampleData);

// ---- sim/sad_synth_model.sv ----
// frequency synthesizer model: drive pulse and range lines
// assumes fire is a one-cycle bench request
`timescale 1ns/10ps
module sad_synth_model (
  input  wire logic       clock,
  input  wire logic       fire,
  input  wire logic [1:0] rangeCode,
  output logic            synthDrivePulse,
  output logic            rangeSelectAN,
  output logic            rangeSelectBN
);
  logic [1:0] left_q = 2'h0;
  // two clocks high so the two-flop sync never misses it
  always @(posedge clock) begin
    if (fire) begin
      left_q <= 2'h2;
    end else if (left_q != 2'h0) begin
      left_q <= left_q - 2'h1;
    end
  end
  assign synthDrivePulse = left_q != 2'h0;
  assign rangeSelectAN = rangeCode != 2'h1;
  assign rangeSelectBN = rangeCode != 2'h2;
endmodule

// ---- sim/sad_divider_test.sv ----
// self-checking bench of the sine address divider
// assumes the synthesizer model and the port checker
`timescale 1ns/10ps
module sad_divider_test;
  logic                 clock = 1'b0;
  logic                 resetn = 1'b0;
  logic                 fire = 1'b0;
  logic                 holdReady = 1'b0;
  logic                 sampleReady = 1'b1;
  logic                 regWrite = 1'b0;
  logic                 regRead = 1'b0;
  logic [1:0]           rangeCode = 2'h0;
  logic [7:0]           regAddr = 8'h00;
  logic [31:0]          regWrData = 32'h0;
  logic [31:0]          regRdData;
  logic [8:0]           romAddr;
  logic [6:0]           biasMagnitude;
  logic [7:0]           ampl;
  logic                 synthDrivePulse, rangeSelectAN, rangeSelectBN, polarityNeg, polarityPos;
  logic                 sampleValid, biasNegative;
  sad_pkg::sad_sample_t sampleData;
  int                   fails = 0, compares = 0, seed = 37387, cycles = 0, takes = 0, step, t0;
  sad_synth_model i_sad_synth_model (.clock, .fire, .rangeCode, .synthDrivePulse, .rangeSelectAN,
    .rangeSelectBN);
  sad_divider i_sad_divider (.clock, .resetn, .synthDrivePulse, .rangeSelectAN, .rangeSelectBN, .regAddr,
    .regWrData, .regWrite, .regRead, .regRdData, .romAddr, .polarityNeg, .polarityPos, .sampleValid,
    .sampleReady, .sampleData, .biasNegative, .biasMagnitude);
  initial begin
    forever #4 clock = ~clock;
  end
  // -----------------------------------------------------------------
  // tasks and expectations
  // -----------------------------------------------------------------
  task automatic final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk(regRdData, exp);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clock);
      fire <= 1'b1;
      @(posedge clock);
      fire <= 1'b0;
      repeat (8 + $unsigned($random(seed)) % 3) @(posedge clock);
    end
  endtask
  task automatic resetDut;
    @(posedge clock);
    resetn <= 1'b0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
  endtask
  function automatic logic [8:0] expAddr(input int n, input int s);
    int per, q, r;
    per = 390 / s;
    q = (n / per) % 4;
    r = n % per;
    return (q % 2 == 0) ? 9'(r * s) : 9'(390 - s - r * s);
  endfunction
  function automatic logic [31:0] eocExp(input int i);
    case (i)
      1: return 32'h0d;
      2: return 32'h19;
      3: return 32'h03;
      5: return 32'h7a;
      6: return 32'h6d;
      7: return 32'h84;
      default: return 32'h00;
    endcase
  endfunction
  // -----------------------------------------------------------------
  // consumer, timeout
  // -----------------------------------------------------------------
  always @(posedge clock) begin
    cycles <= cycles + 1;
    sampleReady <= !holdReady && ($random(seed) % 4 != 0);
    if (sampleValid && sampleReady) takes <= takes + 1;
    if (cycles == 60000) begin
      fails = fails + 1;
      final_report();
    end
  end
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    resetDut();
    rd(sad_pkg::REG_STATUS, 32'h0030_0000);
    rd(8'hfc, 32'h0);
    wr(sad_pkg::REG_BIAS, 32'h85);
    #1 chk({biasNegative, biasMagnitude}, 32'h85);
    ampl = 8'($random(seed));
    wr(sad_pkg::REG_AMPL, {24'h0, ampl});
    rd(sad_pkg::REG_AMPL, {24'h0, ampl});
    for (int i = 0; i < 8; i++) begin
      wr(sad_pkg::REG_TBLIDX, i);
      rd(sad_pkg::REG_EOC, eocExp(i));
    end
    wr(sad_pkg::REG_TBLIDX, 32'h1a);
    rd(sad_pkg::REG_ADDEND, 32'h50);
    wr(sad_pkg::REG_TBLIDX, 32'h0c);
    rd(sad_pkg::REG_ADDEND, 32'h00);
    $display("registers done");
    for (int r = 0; r < 3; r++) begin
      step = (r == 0) ? 1 : (r == 1) ? 5 : 10;
      @(posedge clock);
      rangeCode <= 2'(r);
      resetDut();
      pulse(1);
      chk(romAddr, 32'h0);
      wr(sad_pkg::REG_CTRL, 32'h1);
      repeat (8) @(posedge clock);
      for (int n = 1; n <= 1560 / step; n++) begin
        if (n > 1) pulse(1);
        chk({polarityNeg, romAddr}, {(n / (390 / step)) % 4 >= 2, expAddr(n, step)});
      end
    end
    $display("ranges done");
    // stall the stream: 17 words fit, one pulse stays pending, rest merge
    repeat (40) @(posedge clock);
    holdReady <= 1'b1;
    repeat (4) @(posedge clock);
    pulse(20);
    #1 chk(romAddr, expAddr(17, 10));
    chk({sampleValid, sampleData.negative}, 32'h2);
    t0 = takes;
    holdReady <= 1'b0;
    repeat (80) @(posedge clock);
    chk(takes - t0, 18);
    chk(romAddr, expAddr(18, 10));
    $display("stream done");
    final_report();
  end
endmodule
